// >>> inc/rxt_map.vh
// constants for the instruction execute tail: offsets, fields, resets, opcodes
`ifndef RXT_MAP_VH
`define RXT_MAP_VH

// bus register byte offsets
`define RXT_OFF_CTRL       12'h000
`define RXT_OFF_FLAGS      12'h004
`define RXT_OFF_PC         12'h008
`define RXT_OFF_ACC        12'h00C
`define RXT_OFF_INSTR      12'h010

// control register fields and reset value
`define RXT_CTRL_RUN_BIT   0
`define RXT_CTRL_STEP_BIT  1
`define RXT_CTRL_RESET     1'b1

// flag register: layout, file address and reset value
`define RXT_FILE_FLAGS     5'h03
`define RXT_FLAG_Z         0
`define RXT_FLAG_DC        1
`define RXT_FLAG_C         2
`define RXT_FLAG_TIMEOUT   4
`define RXT_FLAG_PAGE_LO   5
`define RXT_FLAG_PAGE_HI   6
`define RXT_FLAGS_RESET    8'h18

// instruction word fields
`define RXT_DEST_BIT       5
`define RXT_DIR_FIRST      3'h5
`define RXT_DIR_COUNT      3
`define RXT_DIR_RESET      8'hFF
`define RXT_BUBBLE         12'h000
`define RXT_KICK_WORD      12'h004

// opcode groups
`define RXT_OP_JUMP        3'h5
`define RXT_OP_RETURN      4'h8
`define RXT_OP_LITERAL     4'hC
`define RXT_OP_DEC         6'h03
`define RXT_OP_INC         6'h0A
`define RXT_OP_DECSKIP     6'h0B
`define RXT_OP_INCSKIP     6'h0F
`define RXT_OP_OR          6'h04
`define RXT_OP_COPY        6'h08
`define RXT_OP_SUB         6'h02
`define RXT_OP_ROTL        6'h0D
`define RXT_OP_ROTR        6'h0C
`define RXT_OP_SWAP        6'h0E

// alu function select
`define RXT_ALU_COPY       3'h0
`define RXT_ALU_INC        3'h1
`define RXT_ALU_DEC        3'h2
`define RXT_ALU_OR         3'h3
`define RXT_ALU_SUB        3'h4
`define RXT_ALU_ROTL       3'h5
`define RXT_ALU_ROTR       3'h6
`define RXT_ALU_SWAP       3'h7

`endif

// >>> rtl/rxt_regfile.v
// data register file with registered, write-first read port
`timescale 1ns/10ps
module rxt_regfile #(
  parameter ADDR_W = 5,
  parameter DATA_W = 8
) (
  // clock and reset
  input  wire              sys_clk,
  input  wire              nrst,
  // write port
  input  wire              wrEn,
  input  wire [ADDR_W-1:0] wrAddr,
  input  wire [DATA_W-1:0] wrData,
  // read port
  input  wire [ADDR_W-1:0] rdAddr,
  output reg  [DATA_W-1:0] rdData
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // write-first so an operand fetched behind a write sees the new value
  always @(posedge sys_clk) begin
    if (!nrst) begin
      rdData <= {DATA_W{1'b0}};
    end else if (wrEn && (wrAddr == rdAddr)) begin
      rdData <= wrData;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// >>> rtl/rxt_alu.v
// byte alu for the file-register instructions
`timescale 1ns/10ps
`include "rxt_map.vh"
module rxt_alu (
  // operands
  input  wire [2:0] aluSel,
  input  wire [7:0] fileVal,
  input  wire [7:0] accVal,
  input  wire       carryIn,
  // results
  output reg  [7:0] result,
  output reg        carryOut,
  output reg        digitCarryOut
);

  wire [8:0] subSum;
  wire [4:0] subNib;

  // two's complement: f + ~w + 1, carry means no borrow
  assign subSum = {1'b0, fileVal} + {1'b0, ~accVal} + 9'h001;
  assign subNib = {1'b0, fileVal[3:0]} + {1'b0, ~accVal[3:0]} + 5'h01;

  always @* begin
    result        = fileVal;
    carryOut      = carryIn;
    digitCarryOut = 1'b0;
    case (aluSel)
      `RXT_ALU_COPY: result = fileVal;
      `RXT_ALU_INC:  result = fileVal + 8'h01;
      `RXT_ALU_DEC:  result = fileVal - 8'h01;
      `RXT_ALU_OR:   result = fileVal | accVal;
      `RXT_ALU_SUB: begin
        result        = subSum[7:0];
        carryOut      = subSum[8];
        digitCarryOut = subNib[4];
      end
      `RXT_ALU_ROTL: begin
        result   = {fileVal[6:0], carryIn};
        carryOut = fileVal[7];
      end
      `RXT_ALU_ROTR: begin
        result   = {carryIn, fileVal[7:1]};
        carryOut = fileVal[0];
      end
      `RXT_ALU_SWAP: result = {fileVal[3:0], fileVal[7:4]};
      default:       result = fileVal;
    endcase
  end

endmodule

// >>> rtl/rxt_core.v
// fetch/execute pipeline and decoder for the second half of the instruction set
`timescale 1ns/10ps
`include "rxt_map.vh"
module rxt_core #(
  parameter PC_WIDTH  = 11,
  parameter FILE_ADDR = 5
) (
  // clock and reset
  input  wire                sys_clk,
  input  wire                nrst,
  // apb slave
  input  wire [11:0]         paddr,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output wire                pready,
  output wire                pslverr,
  // program memory
  output wire [PC_WIDTH-1:0] progAddr,
  input  wire [11:0]         progData,
  // return stack
  input  wire [PC_WIDTH-1:0] stackTop,
  output reg                 stackPop,
  // watchdog and port directions
  output reg                 watchdogClearOut,
  output wire [23:0]         portDirection
);

  // pipeline and architectural state
  reg  [PC_WIDTH-1:0] pcReg;
  reg  [11:0]         instrReg;
  reg                 instrValidReg;
  reg  [7:0]          accReg;
  reg  [7:0]          flagsReg;
  reg  [7:0]          flagsNext;
  reg                 runReg;
  reg                 stepReg;

  // decode outputs
  reg  [2:0]          aluSel;
  reg                 isAlu;
  reg                 updZero;
  reg                 updCarry;
  reg                 updDigit;
  reg                 skipOnZero;
  reg                 isJump;
  reg                 isReturn;
  reg                 isLiteral;
  reg                 isDirection;
  reg                 isKick;

  wire                advance;
  wire                exec;
  wire                flush;
  wire [4:0]          fileAddr;
  wire                destFile;
  wire [7:0]          literal;
  wire [7:0]          ramData;
  wire [7:0]          fileVal;
  wire [7:0]          aluResult;
  wire                aluCarry;
  wire                aluDigit;
  wire                aluZero;
  wire                fileWrite;
  wire                ramWrite;
  wire [4:0]          ramReadAddr;
  wire [10:0]         jumpFull;
  wire [PC_WIDTH-1:0] jumpTarget;
  wire                apbSetup;
  wire                apbAccess;
  reg  [31:0]         readValue;
  reg                 addrHit;

  // stalled core holds every stage; a step pulse advances it once
  assign advance  = runReg | stepReg;
  assign exec     = advance & instrValidReg;
  assign fileAddr = instrReg[4:0];
  assign destFile = instrReg[`RXT_DEST_BIT];
  assign literal  = instrReg[7:0];
  assign progAddr = pcReg;

  // the flag register lives in the core, not in the ram
  assign fileVal  = (fileAddr == `RXT_FILE_FLAGS) ? flagsReg : ramData;
  assign aluZero  = (aluResult == 8'h00);

  // decode of the current execute-stage word
  always @* begin
    aluSel      = `RXT_ALU_COPY;
    isAlu       = 1'b0;
    updZero     = 1'b0;
    updCarry    = 1'b0;
    updDigit    = 1'b0;
    skipOnZero  = 1'b0;
    isJump      = 1'b0;
    isReturn    = 1'b0;
    isLiteral   = 1'b0;
    isDirection = 1'b0;
    isKick      = 1'b0;
    if (instrReg[11:9] == `RXT_OP_JUMP) begin
      isJump = 1'b1;
    end else if (instrReg[11:8] == `RXT_OP_RETURN) begin
      isReturn = 1'b1;
    end else if (instrReg[11:8] == `RXT_OP_LITERAL) begin
      isLiteral = 1'b1;
    end else if (instrReg == `RXT_KICK_WORD) begin
      isKick = 1'b1;
    end else if ((instrReg[11:3] == 9'h000) && (instrReg[2:0] >= `RXT_DIR_FIRST)) begin
      isDirection = 1'b1;
    end else begin
      case (instrReg[11:6])
        `RXT_OP_DEC: begin
          aluSel  = `RXT_ALU_DEC;
          isAlu   = 1'b1;
          updZero = 1'b1;
        end
        `RXT_OP_INC: begin
          aluSel  = `RXT_ALU_INC;
          isAlu   = 1'b1;
          updZero = 1'b1;
        end
        `RXT_OP_DECSKIP: begin
          aluSel     = `RXT_ALU_DEC;
          isAlu      = 1'b1;
          skipOnZero = 1'b1;
        end
        `RXT_OP_INCSKIP: begin
          aluSel     = `RXT_ALU_INC;
          isAlu      = 1'b1;
          skipOnZero = 1'b1;
        end
        `RXT_OP_OR: begin
          aluSel  = `RXT_ALU_OR;
          isAlu   = 1'b1;
          updZero = 1'b1;
        end
        `RXT_OP_COPY: begin
          aluSel  = `RXT_ALU_COPY;
          isAlu   = 1'b1;
          updZero = 1'b1;
        end
        `RXT_OP_SUB: begin
          aluSel   = `RXT_ALU_SUB;
          isAlu    = 1'b1;
          updZero  = 1'b1;
          updCarry = 1'b1;
          updDigit = 1'b1;
        end
        `RXT_OP_ROTL: begin
          aluSel   = `RXT_ALU_ROTL;
          isAlu    = 1'b1;
          updCarry = 1'b1;
        end
        `RXT_OP_ROTR: begin
          aluSel   = `RXT_ALU_ROTR;
          isAlu    = 1'b1;
          updCarry = 1'b1;
        end
        `RXT_OP_SWAP: begin
          aluSel = `RXT_ALU_SWAP;
          isAlu  = 1'b1;
        end
        default: begin
          isAlu = 1'b0;
        end
      endcase
    end
  end

  rxt_alu uAlu (
    .aluSel        (aluSel),
    .fileVal       (fileVal),
    .accVal        (accReg),
    .carryIn       (flagsReg[`RXT_FLAG_C]),
    .result        (aluResult),
    .carryOut      (aluCarry),
    .digitCarryOut (aluDigit)
  );

  // result steering
  assign fileWrite = exec & isAlu & destFile;
  assign ramWrite  = fileWrite & (fileAddr != `RXT_FILE_FLAGS);

  // operand read is issued with the fetch so it lines up with execute
  assign ramReadAddr = advance ? progData[4:0] : instrReg[4:0];

  rxt_regfile #(
    .ADDR_W (FILE_ADDR),
    .DATA_W (8)
  ) uFile (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .wrEn    (ramWrite),
    .wrAddr  (fileAddr[FILE_ADDR-1:0]),
    .wrData  (aluResult),
    .rdAddr  (ramReadAddr[FILE_ADDR-1:0]),
    .rdData  (ramData)
  );

  // narrow counters simply drop the page bits
  assign jumpFull   = {flagsReg[`RXT_FLAG_PAGE_HI:`RXT_FLAG_PAGE_LO], instrReg[8:0]};
  assign jumpTarget = jumpFull[PC_WIDTH-1:0];

  // a taken branch or skip voids the word fetched behind it
  assign flush = exec & (isJump | isReturn | (skipOnZero & aluZero));

  // flag update; file write first, then hardware flag effects on top
  always @* begin
    flagsNext = flagsReg;
    if (fileWrite && (fileAddr == `RXT_FILE_FLAGS)) begin
      flagsNext = aluResult;
    end
    if (exec && updZero) begin
      flagsNext[`RXT_FLAG_Z] = aluZero;
    end
    if (exec && updCarry) begin
      flagsNext[`RXT_FLAG_C] = aluCarry;
    end
    if (exec && updDigit) begin
      flagsNext[`RXT_FLAG_DC] = aluDigit;
    end
    if (exec && isKick) begin
      flagsNext[`RXT_FLAG_TIMEOUT] = 1'b1;
    end
  end

  // fetch stage and program counter
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pcReg         <= {PC_WIDTH{1'b0}};
      instrReg      <= `RXT_BUBBLE;
      instrValidReg <= 1'b0;
    end else if (advance) begin
      instrReg <= progData;
      if (exec && isJump) begin
        pcReg <= jumpTarget;
      end else if (exec && isReturn) begin
        pcReg <= stackTop;
      end else begin
        pcReg <= pcReg + {{(PC_WIDTH-1){1'b0}}, 1'b1};
      end
      instrValidReg <= ~flush;
    end
  end

  // accumulator, flags and side outputs
  always @(posedge sys_clk) begin
    if (!nrst) begin
      accReg           <= 8'h00;
      flagsReg         <= `RXT_FLAGS_RESET;
      stackPop         <= 1'b0;
      watchdogClearOut <= 1'b0;
    end else begin
      flagsReg         <= flagsNext;
      stackPop         <= exec & isReturn;
      watchdogClearOut <= exec & isKick;
      if (exec && isAlu && !destFile) begin
        accReg <= aluResult;
      end else if (exec && (isLiteral || isReturn)) begin
        accReg <= literal;
      end
    end
  end

  // port direction registers, one per selectable file
  genvar g;
  generate
    for (g = 0; g < `RXT_DIR_COUNT; g = g + 1) begin : gDir
      reg [7:0] dirReg;
      always @(posedge sys_clk) begin
        if (!nrst) begin
          dirReg <= `RXT_DIR_RESET;
        end else if (exec && isDirection && (instrReg[2:0] == (`RXT_DIR_FIRST + g))) begin
          dirReg <= accReg;
        end
      end
      assign portDirection[8*g+7:8*g] = dirReg;
    end
  endgenerate

  // apb slave: zero wait states, read data captured in setup
  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable;
  assign pready    = 1'b1;
  assign pslverr   = apbAccess & ~addrHit;

  always @* begin
    readValue = 32'h0000_0000;
    addrHit   = 1'b1;
    if (paddr == `RXT_OFF_CTRL) begin
      readValue[`RXT_CTRL_RUN_BIT] = runReg;
    end else if (paddr == `RXT_OFF_FLAGS) begin
      readValue[7:0] = flagsReg;
    end else if (paddr == `RXT_OFF_PC) begin
      readValue[PC_WIDTH-1:0] = pcReg;
    end else if (paddr == `RXT_OFF_ACC) begin
      readValue[7:0] = accReg;
    end else if (paddr == `RXT_OFF_INSTR) begin
      readValue[11:0] = instrReg;
      readValue[16]   = instrValidReg;
    end else begin
      addrHit = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup && !pwrite) begin
      prdata <= readValue;
    end
  end

  // control: run level and a self-clearing single-step pulse
  always @(posedge sys_clk) begin
    if (!nrst) begin
      runReg  <= `RXT_CTRL_RESET;
      stepReg <= 1'b0;
    end else if (apbAccess && pwrite && (paddr == `RXT_OFF_CTRL)) begin
      runReg  <= pwdata[`RXT_CTRL_RUN_BIT];
      stepReg <= pwdata[`RXT_CTRL_STEP_BIT] & ~pwdata[`RXT_CTRL_RUN_BIT];
    end else begin
      stepReg <= 1'b0;
    end
  end

endmodule

// >>> tb/rxt_prog_mem.sv
// program memory and return stack facing the execute tail
`timescale 1ns/10ps
module rxt_prog_mem #(
  parameter PC_WIDTH = 11
) (
  // clock
  input  wire                sys_clk,
  // program memory
  input  wire [PC_WIDTH-1:0] progAddr,
  output wire [11:0]         progData,
  // return stack
  input  wire                stackPop,
  output wire [PC_WIDTH-1:0] stackTop
);
  logic [11:0]         mem [0:(1<<PC_WIDTH)-1];
  logic [PC_WIDTH-1:0] topEntry_reg = '0;

  // asynchronous read: the core issues the word's operand read in the cycle it is fetched and decodes it a cycle later
  assign progData = mem[progAddr];
  assign stackTop = topEntry_reg;

  // a popped entry is gone: show its inverse so a late sample is caught
  always @(posedge sys_clk) begin
    if (stackPop) begin
      topEntry_reg <= ~topEntry_reg;
    end
  end
endmodule

// >>> tb/rxt_props.sv
// port-level checks for the execute tail, bound into the core
`timescale 1ns/10ps
`include "rxt_map.vh"
module rxt_props #(
  parameter PC_WIDTH = 11
) (
  // clock and reset
  input wire                sys_clk,
  input wire                nrst,
  // apb
  input wire [11:0]         paddr,
  input wire                psel,
  input wire                penable,
  input wire                pwrite,
  input wire [31:0]         pwdata,
  input wire                pslverr,
  // core side
  input wire [PC_WIDTH-1:0] progAddr,
  input wire [11:0]         progData,
  input wire [PC_WIDTH-1:0] stackTop,
  input wire                stackPop,
  input wire                watchdogClearOut,
  input wire [23:0]         portDirection
);
  logic [11:0] fetchDly_reg;
  logic [11:0] execDly_reg;
  logic        isJump;
  logic        isRet;
  logic        isFlow;
  logic        runSeen_reg;
  logic        stepSeen_reg;
  logic        adv;

  // mirror of the run level and step pulse, decoded from the bus writes
  always @(posedge sys_clk) begin
    if (!nrst) begin
      runSeen_reg  <= `RXT_CTRL_RESET;
      stepSeen_reg <= 1'b0;
    end else if (psel && penable && pwrite && paddr == `RXT_OFF_CTRL) begin
      runSeen_reg  <= pwdata[`RXT_CTRL_RUN_BIT];
      stepSeen_reg <= pwdata[`RXT_CTRL_STEP_BIT] & ~pwdata[`RXT_CTRL_RUN_BIT];
    end else begin
      stepSeen_reg <= 1'b0;
    end
  end
  assign adv = runSeen_reg | stepSeen_reg;

  // the word fetched two advancing edges ago is the one whose effects show now
  always @(posedge sys_clk) begin
    if (!nrst) begin
      fetchDly_reg <= `RXT_BUBBLE;
      execDly_reg  <= `RXT_BUBBLE;
    end else if (adv) begin
      fetchDly_reg <= progData;
      execDly_reg  <= fetchDly_reg;
    end
  end

  // limitation: a jump sitting in a flushed slot would be taken as executed
  assign isJump = execDly_reg[11:9] == `RXT_OP_JUMP;
  assign isRet  = execDly_reg[11:8] == `RXT_OP_RETURN;
  assign isFlow = isJump || isRet || execDly_reg[11:6] == `RXT_OP_DECSKIP
                  || execDly_reg[11:6] == `RXT_OP_INCSKIP;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_jump_target: assert property (isJump |-> progAddr[8:0] == execDly_reg[8:0])
    else $error("jump target not fetched");
  a_pc_step: assert property ($past(nrst) && $past(adv) && !isFlow |->
      progAddr == $past(progAddr) + 1'b1)
    else $error("program counter did not step");
  a_pc_hold: assert property ($past(nrst) && !$past(adv) |->
      progAddr == $past(progAddr))
    else $error("program counter moved while stalled");
  a_ret_target: assert property ($past(adv) && isRet |-> progAddr == $past(stackTop))
    else $error("return target wrong");
  a_pop_cause: assert property (stackPop |-> isRet)
    else $error("pop without return");
  a_pop_single: assert property (stackPop |=> !stackPop)
    else $error("pop longer than one cycle");
  a_kick_cause: assert property (watchdogClearOut |-> execDly_reg == `RXT_KICK_WORD)
    else $error("watchdog clear without kick");
  a_dir_cause: assert property (!$stable(portDirection) |->
      execDly_reg[11:3] == 9'h000 && execDly_reg[2:0] >= `RXT_DIR_FIRST)
    else $error("direction changed without load");
  a_err_decode: assert property (psel && penable && paddr[1:0] == 2'b00 |->
      pslverr == (paddr > `RXT_OFF_INSTR))
    else $error("bus error decode wrong");
endmodule

bind rxt_core rxt_props #(.PC_WIDTH(PC_WIDTH)) rxt_props_inst (
  .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata),
  .pslverr(pslverr), .progAddr(progAddr), .progData(progData), .stackTop(stackTop),
  .stackPop(stackPop), .watchdogClearOut(watchdogClearOut), .portDirection(portDirection)
);

// >>> tb/risc8_instr_exec_tail_tb.sv
// self-checking bench for the execute tail: short programs, then register reads
`timescale 1ns/10ps
`include "rxt_map.vh"
module risc8_instr_exec_tail_tb;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [10:0] progAddr;
  logic [11:0] progData;
  logic [10:0] stackTop;
  logic        stackPop;
  logic        watchdogClearOut;
  logic [23:0] portDirection;
  logic [31:0] rd;
  logic        er;
  logic [31:0] pcHeld;
  logic [23:0] progQ[$];
  int          err_total = 0;
  int          n_compared = 0;
  int          kickSeen = 0;
  int          popSeen = 0;

  always #25 sys_clk = ~sys_clk;

  // pulse counters, sampled mid-cycle where the registered outputs are settled
  always @(negedge sys_clk) begin
    if (watchdogClearOut === 1'b1) begin
      kickSeen++;
    end
    if (stackPop === 1'b1) begin
      popSeen++;
    end
  end

  rxt_core #(.PC_WIDTH(11), .FILE_ADDR(5)) rxt_core_inst (
    .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progAddr(progAddr), .progData(progData), .stackTop(stackTop), .stackPop(stackPop),
    .watchdogClearOut(watchdogClearOut), .portDirection(portDirection)
  );

  rxt_prog_mem #(.PC_WIDTH(11)) rxt_prog_mem_inst (
    .sys_clk(sys_clk), .progAddr(progAddr), .progData(progData),
    .stackPop(stackPop), .stackTop(stackTop)
  );

  task automatic finish_test;
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h", $time, s, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x, input string s,
                      input logic [31:0] m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h00000000);
    cmp(rd & m, x, s);
    cmp({31'h00000000, er}, {31'h00000000, a > `RXT_OFF_INSTR}, "error response");
  endtask

  // reset first so the core never fetches a half-loaded program
  task automatic start;
    nrst <= 1'b0;
    foreach (rxt_prog_mem_inst.mem[i]) rxt_prog_mem_inst.mem[i] = `RXT_BUBBLE;
    foreach (progQ[i]) rxt_prog_mem_inst.mem[progQ[i][22:12]] = progQ[i][11:0];
    rxt_prog_mem_inst.topEntry_reg = 11'h020;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (60) @(posedge sys_clk);
  endtask

  initial begin
    // file ops on the flag register, the only file with a known value
    progQ = '{24'h000203, 24'h001103, 24'h002383, 24'h003083, 24'h0040C3, 24'h0052A3,
              24'h006083, 24'h007303, 24'h008A08};
    start();
    rchk(`RXT_OFF_ACC, 32'h0000008F, "acc");
    rchk(`RXT_OFF_FLAGS, 32'h0000001A, "flags");
    rchk(`RXT_OFF_PC, 32'h00000008, "loop pc", 32'hFFFFFFFE);
    rchk(`RXT_OFF_CTRL, 32'h00000001, "control");
    // skips, paged jump, kick, direction load, return; flushed literals must not load acc
    progQ = '{24'h000C19, 24'h0010A3, 24'h002C07, 24'h003123, 24'h0043E3, 24'h0052C3,
              24'h0063C3, 24'h007C55, 24'h008A10, 24'h009C66, 24'h610004, 24'h611006,
              24'h61283C, 24'h613C77, 24'h020A20, 24'h620A20};
    start();
    rchk(`RXT_OFF_ACC, 32'h0000003C, "acc");
    rchk(`RXT_OFF_FLAGS, 32'h000000FF, "flags");
    rchk(`RXT_OFF_PC, 32'h00000620, "paged pc", 32'hFFFFFFFE);
    cmp({8'h00, portDirection}, 32'h00FF00FF, "directions");
    cmp(kickSeen, 32'h00000001, "kick pulses");
    cmp(popSeen, 32'h00000001, "stack pops");
    // stop the core in its closing loop, then single-step it once
    apb(1'b1, `RXT_OFF_CTRL, 32'h00000000);
    rchk(`RXT_OFF_PC, 32'h00000620, "stopped pc", 32'hFFFFFFFE);
    pcHeld = rd;
    rchk(`RXT_OFF_PC, pcHeld, "held pc");
    apb(1'b1, `RXT_OFF_CTRL, 32'h00000002);
    rchk(`RXT_OFF_PC, pcHeld ^ 32'h00000001, "stepped pc");
    rchk(`RXT_OFF_CTRL, 32'h00000000, "stopped control");
    apb(1'b1, `RXT_OFF_ACC, 32'h00000055);
    rchk(`RXT_OFF_ACC, 32'h0000003C, "read-only acc");
    rchk(12'h020, 32'h00000000, "unmapped");
    finish_test();
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
endmodule
